// ---- rtl/pss_core.sv ----
// Profiler state save and restore engine
`timescale 1ns/1ps
// Function
// - Feature mask bit 62 gates profiler restore and availability; save does not check it.
// - Save region is 128 bytes at offset 832 of save area.
// - Reserved fields in the save region are zero.
// - Disabled profiler: save stores nothing, clears bitmap bit 62.
// - Enabled profiler: save copies raw state, sets bitmap bit 62.
// - Restore ignored when feature bit 62 and bitmap bit clear, or feature set and requested mask bit 62 clear.
// - Bitmap bit 62 clear: restore zeros address, disables, clears state.
// - Ring size below minimum disables profiler and ends restore.
// - Ring size rounded down to event record multiple.
// - Head offset past size minus record size becomes zero.
// - Head offset rounded down to event record multiple.
// - Saved flags enable configured events and load counters; others off.
// - Pending record with nonzero low byte loaded, written once privilege is 3.
// - Restore overwrites enabled state without saving it.
// - Restore raises no threshold interrupt; next store does.
// - Unrestored state fetch from control block requested as load completes.
// - Privilege 0 reloads addresses without validation.
// - Nonzero privilege checks first and last byte of block and ring.
// - Store check fails on read-only segment, or beyond limit when not in 64-bit mode.
// - Failed address check disables profiler, no fault.
// - Feature bit clear but bitmap bit set raises protection fault 0.
module pss_core (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic [63:0]                feature_enable_mask,
    input  wire logic [31:0]                requested_feature_hi,
    input  wire logic [1:0]                 privilege_level,
    input  wire pss_pkg::pss_seg_s          data_segment,
    input  wire logic [pss_pkg::NUM_EVENTS-1:0] profiler_config_evt,
    input  wire logic                       save_req,
    input  wire logic                       restore_req,
    input  wire logic                       saved_bitmap_bit,
    input  wire pss_pkg::pss_image_s        restore_image,
    input  wire logic                       record_store,
    input  wire logic [pss_pkg::NUM_EVENTS-1:0] event_tick,
    output logic                            profiler_avail,
    output logic                            save_done,
    output logic                            save_bitmap_bit,
    output pss_pkg::pss_image_s             save_image,
    output logic [11:0]                     area_offset,
    output logic [11:0]                     area_size,
    output logic                            restore_done,
    output logic                            gp_fault,
    output logic                            profiler_enabled,
    output pss_pkg::pss_image_s             live_state,
    output logic [pss_pkg::NUM_EVENTS-1:0]  event_enabled,
    output logic                            pending_valid,
    output logic                            pending_write,
    output logic                            threshold_arm,
    output logic                            cb_fetch_req
);
    import pss_pkg::*;

    typedef struct packed {
        pss_state_e            state;
        pss_image_s            img;
        pss_image_s            live;
        logic [NUM_EVENTS-1:0] evt_en;
        logic                  en;
        logic                  pend;
        logic                  pend_wr;
        logic                  cb_fetch;
        logic                  thr_arm;
        logic                  sv_done;
        logic                  sv_bit;
        pss_image_s            sv_img;
        logic                  rs_done;
        logic                  gp;
        logic                  avail;
        logic [1:0]            chk_step;
    } pss_core_s;

    pss_core_s   st_ff;
    pss_core_s   nxt_st;
    logic        feat;
    logic        chk_start;
    logic [63:0] chk_addr;
    logic [31:0] chk_size;
    logic        chk_ok;
    logic [31:0] rsz;
    logic [31:0] hoff;

    assign feat = feature_enable_mask[FEAT_BIT];

    pss_seg_check u_chk (
        .clock (clock),
        .rst_n (rst_n),
        .start (chk_start),
        .seg   (data_segment),
        .addr  (chk_addr),
        .size  (chk_size),
        .ok_ff (chk_ok)
    );

    always_comb begin
        chk_start = 1'b0;
        chk_addr  = st_ff.img.cb_addr;
        chk_size  = CB_SIZE;
        if (st_ff.state == PSS_CHECK && !st_ff.chk_step[0]) begin
            chk_start = 1'b1;
            if (st_ff.chk_step[1]) begin
                chk_addr = st_ff.img.ring_base;
                chk_size = st_ff.img.ring_size;
            end
        end
    end

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.sv_done = 1'b0;
        nxt_st.rs_done = 1'b0;
        nxt_st.gp      = 1'b0;
        nxt_st.pend_wr = 1'b0;
        nxt_st.cb_fetch = 1'b0;
        nxt_st.avail   = feat;
        rsz  = st_ff.img.ring_size & ~(EVT_SIZE - 32'h1);
        hoff = st_ff.img.head_off;
        if (hoff > rsz - EVT_SIZE) begin
            hoff = RST_HEAD;
        end
        hoff = hoff & ~(EVT_SIZE - 32'h1);
        if (st_ff.state == PSS_IDLE && st_ff.en) begin
            for (int i = 0; i < NUM_EVENTS; i++) begin
                if (st_ff.evt_en[i] && event_tick[i]) begin
                    nxt_st.live.counters[i] =
                        st_ff.live.counters[i] - 32'h1;
                end
            end
            if (st_ff.pend && privilege_level == 2'b11) begin
                nxt_st.pend    = 1'b0;
                nxt_st.pend_wr = 1'b1;
            end
            if (record_store) begin
                nxt_st.thr_arm = 1'b1;
            end
        end
        case (st_ff.state)
            PSS_IDLE: begin
                if (save_req) begin
                    nxt_st.sv_done = 1'b1;
                    if (st_ff.live.cb_addr == RST_ADDR) begin
                        nxt_st.sv_bit = 1'b0;
                        nxt_st.sv_img = '0;
                    end else begin
                        nxt_st.sv_bit = 1'b1;
                        nxt_st.sv_img = st_ff.live;
                        nxt_st.sv_img.flags = {8'h0,
                            1'b0, st_ff.evt_en, 1'b0};
                    end
                end else if (restore_req) begin
                    if (!feat && saved_bitmap_bit) begin
                        nxt_st.gp      = 1'b1;
                        nxt_st.rs_done = 1'b1;
                    end else if (!feat ||
                                 !requested_feature_hi[REQ_HI_BIT]) begin
                        nxt_st.rs_done = 1'b1;
                    end else if (!saved_bitmap_bit) begin
                        nxt_st.live    = '0;
                        nxt_st.evt_en  = '0;
                        nxt_st.en      = 1'b0;
                        nxt_st.pend    = 1'b0;
                        nxt_st.rs_done = 1'b1;
                    end else begin
                        nxt_st.img      = restore_image;
                        nxt_st.en       = 1'b0;
                        nxt_st.evt_en   = '0;
                        nxt_st.chk_step = 2'b00;
                        nxt_st.state    = PSS_CHECK;
                    end
                end
            end
            PSS_CHECK: begin
                if (st_ff.img.ring_size < RING_MIN) begin
                    nxt_st.live    = '0;
                    nxt_st.pend    = 1'b0;
                    nxt_st.state   = PSS_DONE;
                end else if (privilege_level == 2'b00) begin
                    nxt_st.state   = PSS_LOAD;
                end else if (st_ff.chk_step[0] && !chk_ok) begin
                    nxt_st.live    = '0;
                    nxt_st.pend    = 1'b0;
                    nxt_st.state   = PSS_DONE;
                end else if (st_ff.chk_step == 2'b11) begin
                    nxt_st.state   = PSS_LOAD;
                end else begin
                    nxt_st.chk_step = st_ff.chk_step + 2'b01;
                end
            end
            PSS_LOAD: begin
                nxt_st.live           = st_ff.img;
                nxt_st.live.ring_size = rsz;
                nxt_st.live.head_off  = hoff;
                nxt_st.live.filters   = 32'h0;
                nxt_st.thr_arm        = 1'b0;
                for (int i = 0; i < NUM_EVENTS; i++) begin
                    if (!(st_ff.img.flags[i+EVT_LO] &&
                          profiler_config_evt[i])) begin
                        nxt_st.live.counters[i] = 32'h0;
                    end
                end
                nxt_st.evt_en = st_ff.img.flags[EVT_LO +: NUM_EVENTS]
                              & profiler_config_evt;
                nxt_st.pend   = st_ff.img.pend_rec[7:0] != 8'h0;
                nxt_st.en     = 1'b1;
                nxt_st.cb_fetch = 1'b1;
                nxt_st.state  = PSS_DONE;
            end
            PSS_DONE: begin
                nxt_st.rs_done = 1'b1;
                nxt_st.state   = PSS_IDLE;
            end
            default: begin
                nxt_st.state = PSS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff       <= '0;
            st_ff.state <= PSS_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign profiler_avail   = st_ff.avail;
    assign save_done        = st_ff.sv_done;
    assign save_bitmap_bit  = st_ff.sv_bit;
    assign save_image       = st_ff.sv_img;
    assign area_offset      = AREA_OFFSET;
    assign area_size        = AREA_SIZE;
    assign restore_done     = st_ff.rs_done;
    assign gp_fault         = st_ff.gp;
    assign profiler_enabled = st_ff.en;
    assign live_state       = st_ff.live;
    assign event_enabled    = st_ff.evt_en;
    assign pending_valid    = st_ff.pend;
    assign pending_write    = st_ff.pend_wr;
    assign threshold_arm    = st_ff.thr_arm;
    assign cb_fetch_req     = st_ff.cb_fetch;

    save_off_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && save_req && live_state.cb_addr == 64'h0
        |=> save_done && !save_bitmap_bit) else $error("save bit set");
    save_on_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && save_req && live_state.cb_addr != 64'h0
        |=> save_done && save_bitmap_bit) else $error("save bit clear");
    gp_raise_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && !save_req && restore_req && !feat
        && saved_bitmap_bit |=> gp_fault) else $error("no fault");
    skip_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && !save_req && restore_req && feat
        && !requested_feature_hi[30] |=> $stable(live_state.cb_addr))
        else $error("state changed");
    nobit_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && !save_req && restore_req && feat
        && requested_feature_hi[30] && !saved_bitmap_bit
        |=> live_state.cb_addr == 64'h0 && !profiler_enabled)
        else $error("not cleared");
    ring_align_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(cb_fetch_req) |-> live_state.ring_size[4:0] == 5'h0
        && live_state.head_off[4:0] == 5'h0) else $error("misaligned");
    head_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(cb_fetch_req) |-> live_state.head_off
        <= live_state.ring_size - 32'h20) else $error("head past");
    small_ring_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_CHECK && st_ff.img.ring_size < 32'h200
        |=> !profiler_enabled ##1 restore_done) else $error("ring");
    evt_cfg_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_CHECK ##1 st_ff.state == PSS_LOAD
        |=> (event_enabled & ~profiler_config_evt) == '0)
        else $error("evt on");
    busy_count_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_CHECK |-> !profiler_enabled)
        else $error("counting");
    avail_track_a: assert property (@(posedge clock) disable iff (!rst_n)
        1'b1 |=> profiler_avail == $past(feat))
        else $error("avail lag");
    save_copy_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && save_req && live_state.cb_addr != 64'h0
        |=> save_image.cb_addr == $past(live_state.cb_addr))
        else $error("save copy");
    cpl0_load_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_CHECK && st_ff.img.ring_size >= 32'h200
        && privilege_level == 2'b00 |=> st_ff.state == PSS_LOAD)
        else $error("cpl0 check");
    chk_fail_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_CHECK && st_ff.img.ring_size >= 32'h200
        && privilege_level != 2'b00 && st_ff.chk_step[0] && !chk_ok
        |=> !profiler_enabled && st_ff.state == PSS_DONE ##1 restore_done)
        else $error("bad addr kept");
    pend_write_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_IDLE && st_ff.en && pending_valid
        && privilege_level == 2'b11 |=> pending_write && !pending_valid)
        else $error("pend stuck");
    load_thr_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_ff.state == PSS_LOAD |=> !threshold_arm && cb_fetch_req)
        else $error("thr on load");
endmodule : pss_core

// ---- rtl/pss_pkg.sv ----
// Package for the profiler state save and restore block
package pss_pkg;
    localparam int unsigned FEAT_BIT          = 62;
    localparam int unsigned REQ_HI_BIT        = 30;
    localparam logic [11:0] AREA_SIZE         = 12'h080;
    localparam logic [11:0] AREA_OFFSET       = 12'h340;
    localparam int unsigned NUM_EVENTS        = 6;
    localparam logic [31:0] EVT_SIZE          = 32'h0000_0020;
    localparam logic [31:0] RING_MIN          = 32'h0000_0200;
    localparam logic [31:0] CB_SIZE           = 32'h0000_0040;
    localparam logic [31:0] RST_RING_SIZE     = 32'h0000_0000;
    localparam logic [31:0] RST_HEAD          = 32'h0000_0000;
    localparam logic [63:0] RST_ADDR          = 64'h0;
    localparam logic [15:0] FLAG_RSVD_MASK    = 16'hff81;
    localparam int unsigned EVT_LO            = 1;
    localparam int unsigned CHK_STEPS         = 4;

    typedef enum logic [2:0] {
        PSS_IDLE  = 3'b000,
        PSS_CHECK = 3'b001,
        PSS_LOAD  = 3'b011,
        PSS_DONE  = 3'b010
    } pss_state_e;

    // Profiler save region image, as written by save and read by restore
    typedef struct packed {
        logic [63:0]                 cb_addr;
        logic [31:0]                 head_off;
        logic [15:0]                 flags;
        logic [63:0]                 ring_base;
        logic [31:0]                 filters;
        logic [31:0]                 ring_size;
        logic [63:0]                 pend_rec;
        logic [NUM_EVENTS-1:0][31:0] counters;
    } pss_image_s;

    // Segment context used by the store-type checks
    typedef struct packed {
        logic        mode64;
        logic [63:0] base;
        logic [31:0] limit;
        logic        read_only;
    } pss_seg_s;
endpackage : pss_pkg

// ---- rtl/pss_seg_check.sv ----
// Store-type segment check of first and last byte of a region
`timescale 1ns/1ps
module pss_seg_check (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire pss_pkg::pss_seg_s seg,
    input  wire logic [63:0]      addr,
    input  wire logic [31:0]      size,
    output logic                  ok_ff
);
    import pss_pkg::*;

    typedef struct packed {
        logic ok;
    } pss_chk_s;

    pss_chk_s    st_ff;
    pss_chk_s    nxt_st;
    logic [63:0] lin;
    logic [63:0] top;
    logic        lo_ok;
    logic        hi_ok;

    always_comb begin
        lin = addr;
        if (!seg.mode64) begin
            lin = {32'h0, 32'(addr - seg.base)};
        end
        top   = lin + {32'h0, size} - 64'h1;
        lo_ok = seg.mode64 || (lin <= {32'h0, seg.limit});
        hi_ok = seg.mode64 || (top <= {32'h0, seg.limit});
        nxt_st = st_ff;
        if (start) begin
            nxt_st.ok = lo_ok && hi_ok && !seg.read_only;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ok_ff = st_ff.ok;

    ro_fails_a: assert property (@(posedge clock) disable iff (!rst_n)
        start && seg.read_only |=> !ok_ff) else $error("ro seg passed");
endmodule : pss_seg_check

// ---- sim/test_pss_core.sv ----
// Self-checking bench for the profiler state save and restore engine
`timescale 1ns/1ps
module test_pss_core;
    import pss_pkg::*;
    localparam logic [31:0] LIM     = 32'h000f_ffff;
    localparam logic [31:0] CBO [6] = '{32'h100, LIM - 32'h3e, 32'h100,
                                        32'h100, 32'h100, 32'h100};
    localparam logic [31:0] RGO [6] = '{32'h1_0000, 32'h1_0000,
                                        LIM - 32'h3fe, LIM - 32'h3ff,
                                        32'h1_0000, 32'h4000_0000};
    localparam logic [5:0]  RO      = 6'b010000;
    localparam logic [5:0]  M64     = 6'b100000;
    logic                  clock                = 1'b0;
    logic                  rst_n                = 1'b0;
    logic [63:0]           feature_enable_mask  = 64'h0;
    logic [31:0]           requested_feature_hi = 32'h0;
    logic [1:0]            privilege_level      = 2'h0;
    pss_seg_s              data_segment         = '0;
    logic [NUM_EVENTS-1:0] profiler_config_evt  = '0;
    logic                  save_req             = 1'b0;
    logic                  restore_req          = 1'b0;
    logic                  saved_bitmap_bit     = 1'b0;
    pss_image_s            restore_image        = '0;
    logic                  record_store         = 1'b0;
    logic [NUM_EVENTS-1:0] event_tick           = '0;
    logic                  profiler_avail;
    logic                  save_done;
    logic                  save_bitmap_bit;
    pss_image_s            save_image;
    logic [11:0]           area_offset;
    logic [11:0]           area_size;
    logic                  restore_done;
    logic                  gp_fault;
    logic                  profiler_enabled;
    pss_image_s            live_state;
    logic [NUM_EVENTS-1:0] event_enabled;
    logic                  pending_valid;
    logic                  pending_write;
    logic                  threshold_arm;
    logic                  cb_fetch_req;
    pss_image_s            m_st = '0;
    logic                  m_en = 1'b0;
    logic [NUM_EVENTS-1:0] m_evt = '0;
    bit                    m_known = 1'b1;
    logic [31:0]           lf = 32'h0e41;
    int                    n_mismatch = 0;
    int                    comparisons = 0;

    always #25 clock = ~clock;

    pss_core i_pss_core (
        .clock(clock), .rst_n(rst_n),
        .feature_enable_mask(feature_enable_mask),
        .requested_feature_hi(requested_feature_hi),
        .privilege_level(privilege_level), .data_segment(data_segment),
        .profiler_config_evt(profiler_config_evt), .save_req(save_req),
        .restore_req(restore_req), .saved_bitmap_bit(saved_bitmap_bit),
        .restore_image(restore_image), .record_store(record_store),
        .event_tick(event_tick), .profiler_avail(profiler_avail),
        .save_done(save_done), .save_bitmap_bit(save_bitmap_bit),
        .save_image(save_image), .area_offset(area_offset),
        .area_size(area_size), .restore_done(restore_done),
        .gp_fault(gp_fault), .profiler_enabled(profiler_enabled),
        .live_state(live_state), .event_enabled(event_enabled),
        .pending_valid(pending_valid), .pending_write(pending_write),
        .threshold_arm(threshold_arm), .cb_fetch_req(cb_fetch_req)
    );

    function automatic logic [31:0] rnd();
        lf = {1'b0, lf[31:1]} ^ (lf[0] ? 32'h8020_0003 : 32'h0);
        return lf;
    endfunction : rnd

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic tmo;
        n_mismatch++;
        $display("mismatch at %0t: wait ran out", $time);
        end_sim();
    endtask : tmo

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    // Store-type check of first and last byte against the data segment
    function automatic bit seg_ok(input logic [63:0] a,
                                  input logic [31:0] sz);
        logic [63:0] top;
        if (data_segment.read_only) return 1'b0;
        if (data_segment.mode64) return 1'b1;
        a = {32'h0, a[31:0] - data_segment.base[31:0]};
        top = a + {32'h0, sz} - 64'h1;
        return a <= {32'h0, data_segment.limit}
            && top <= {32'h0, data_segment.limit};
    endfunction : seg_ok

    task automatic model_rst(input logic bm, input pss_image_s img);
        logic [31:0] rs;
        bit          ok;
        if (feature_enable_mask[FEAT_BIT] !== 1'b1) return;
        if (requested_feature_hi[REQ_HI_BIT] !== 1'b1) return;
        m_en = 1'b0;
        m_known = 1'b0;
        if (!bm) return;
        rs = img.ring_size & ~(EVT_SIZE - 32'h1);
        ok = privilege_level == 2'h0 || (seg_ok(img.cb_addr, CB_SIZE)
             && seg_ok(img.ring_base, img.ring_size));
        if (img.ring_size < RING_MIN || !ok) return;
        m_st = img;
        m_st.ring_size = rs;
        m_st.head_off = img.head_off > rs - EVT_SIZE ? 32'h0
                        : img.head_off & ~(EVT_SIZE - 32'h1);
        m_evt = img.flags[NUM_EVENTS:EVT_LO] & profiler_config_evt;
        m_en = 1'b1;
        m_known = 1'b1;
    endtask : model_rst

    task automatic chk_state;
        chk(profiler_enabled, m_en, "enable state");
        if (m_known) begin
            chk(live_state.cb_addr, m_st.cb_addr, "block addr");
            chk(live_state.ring_base, m_st.ring_base, "ring base");
            chk(live_state.ring_size, m_st.ring_size, "ring size");
            chk(live_state.head_off, m_st.head_off, "head");
            chk(live_state.filters, 32'h0, "filters");
            chk(event_enabled, m_evt, "event enables");
            chk(pending_valid, m_st.pend_rec[7:0] != 8'h0, "pend");
            for (int i = 0; i < NUM_EVENTS; i++) begin
                if (m_evt[i]) chk(live_state.counters[i],
                                  m_st.counters[i], "counter");
            end
        end
    endtask : chk_state

    task automatic rnd_img(output pss_image_s img);
        img = '0;
        img.cb_addr = {32'h0, rnd() | 32'h40};
        img.ring_base = {32'h0, rnd()};
        img.ring_size = RING_MIN + (rnd() & 32'hfff);
        img.head_off = rnd() & 32'h1fff;
        img.flags = 16'(rnd()) & ~FLAG_RSVD_MASK;
        img.filters = rnd();
        for (int i = 0; i < NUM_EVENTS; i++) img.counters[i] = rnd() | 32'h100;
    endtask : rnd_img

    // One save (sv) or restore request, waits for its answer
    task automatic issue(input bit sv, input logic bm, input pss_image_s img,
                         output logic flt);
        int k;
        flt = 1'b0;
        @(posedge clock);
        save_req <= sv;
        restore_req <= !sv;
        saved_bitmap_bit <= bm;
        restore_image <= img;
        @(posedge clock);
        save_req <= 1'b0;
        restore_req <= 1'b0;
        for (k = 0; k < 20; k++) begin
            #1;
            if (gp_fault === 1'b1) flt = 1'b1;
            if (sv ? save_done === 1'b1 : restore_done === 1'b1) break;
            @(posedge clock);
        end
        if (k == 20) tmo();
        if (!sv) model_rst(bm, img);
    endtask : issue

    initial begin
        pss_image_s img;
        logic       flt;
        int         k;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        feature_enable_mask <= 64'h1 << FEAT_BIT;
        requested_feature_hi <= 32'h1 << REQ_HI_BIT;
        profiler_config_evt <= 6'h2d;
        repeat (2) @(posedge clock);
        #1;
        chk(area_offset, AREA_OFFSET, "offset");
        chk(area_size, AREA_SIZE, "size");
        chk(profiler_avail, 1'b1, "avail");
        issue(1'b1, 1'b0, img, flt);
        chk(save_bitmap_bit, 1'b0, "save disabled");
        $display("test reset and idle save done");
        for (int it = 0; it < 5; it++) begin
            rnd_img(img);
            if (it < 2) img.head_off = (img.ring_size & ~32'h1f) - 32'h1b
                                       - (it == 1 ? 32'h5 : 32'h0);
            issue(1'b0, 1'b1, img, flt);
            chk_state;
        end
        @(posedge clock);
        event_tick <= 6'h3f;
        record_store <= 1'b1;
        @(posedge clock);
        event_tick <= 6'h00;
        record_store <= 1'b0;
        @(posedge clock);
        #1;
        for (int i = 0; i < NUM_EVENTS; i++)
            if (m_evt[i]) m_st.counters[i] -= 32'h1;
        chk_state;
        chk(threshold_arm, 1'b1, "threshold set");
        issue(1'b1, 1'b0, img, flt);
        chk(save_bitmap_bit, 1'b1, "save enabled");
        chk(save_image.cb_addr, m_st.cb_addr, "saved addr");
        chk(save_image.head_off, m_st.head_off, "saved head");
        chk(save_image.flags & FLAG_RSVD_MASK, 16'h0, "reserved");
        $display("test full restores done");
        @(posedge clock);
        requested_feature_hi <= 32'h0;
        rnd_img(img);
        issue(1'b0, 1'b1, img, flt);
        chk_state;
        @(posedge clock);
        requested_feature_hi <= 32'h1 << REQ_HI_BIT;
        feature_enable_mask <= 64'h0;
        issue(1'b0, 1'b1, img, flt);
        chk(flt, 1'b1, "fault");
        chk(profiler_avail, 1'b0, "not avail");
        chk_state;
        issue(1'b0, 1'b0, img, flt);
        chk(flt, 1'b0, "no fault");
        @(posedge clock);
        feature_enable_mask <= 64'h1 << FEAT_BIT;
        img.ring_size = RING_MIN - EVT_SIZE;
        issue(1'b0, 1'b1, img, flt);
        chk_state;
        rnd_img(img);
        issue(1'b0, 1'b1, img, flt);
        chk(threshold_arm, 1'b0, "threshold clear");
        issue(1'b0, 1'b0, img, flt);
        chk(live_state.cb_addr, 64'h0, "addr cleared");
        chk(event_enabled, 6'h0, "events off");
        chk_state;
        issue(1'b1, 1'b0, img, flt);
        chk(save_bitmap_bit, 1'b0, "save after clear");
        $display("test skip fault and defaults done");
        for (int e = 0; e < 6; e++) begin
            @(posedge clock);
            privilege_level <= 2'h3;
            data_segment <= '{M64[e], 64'h1000, LIM, RO[e]};
            rnd_img(img);
            img.cb_addr = 64'h1000 + {32'h0, CBO[e]};
            img.ring_base = 64'h1000 + {32'h0, RGO[e]};
            img.ring_size = 32'h400;
            issue(1'b0, 1'b1, img, flt);
            chk(flt, 1'b0, "check fault");
            chk_state;
        end
        $display("test address checks done");
        @(posedge clock);
        privilege_level <= 2'h0;
        rnd_img(img);
        img.pend_rec = 64'h5a;
        issue(1'b0, 1'b1, img, flt);
        chk_state;
        issue(1'b1, 1'b0, img, flt);
        img = save_image;
        issue(1'b0, 1'b1, img, flt);
        chk_state;
        @(posedge clock);
        privilege_level <= 2'h3;
        for (k = 0; k < 20; k++) begin
            @(posedge clock);
            #1;
            if (pending_write === 1'b1) break;
        end
        if (k == 20) tmo();
        chk(pending_write, 1'b1, "pending write");
        chk(pending_valid, 1'b0, "pending sent");
        $display("test pending record done");
        end_sim();
    end
endmodule : test_pss_core
